// >>> inc/hsph_consts.svh
`ifndef HSPH_CONSTS_SVH
`define HSPH_CONSTS_SVH

// register byte addresses on the device's register port
`define HSPH_A_CFG   5'h00
`define HSPH_A_TXD   5'h04
`define HSPH_A_RXD   5'h08
`define HSPH_A_STAT  5'h0C
`define HSPH_A_LINK  5'h10
`define HSPH_A_ISTAT 5'h14
`define HSPH_A_ICLR  5'h18
`define HSPH_A_IEN   5'h1C

// settings word: divisor, parity, stop bits, flow, high speed, ring poll
`define HSPH_CFG_RST   32'h000000AE
`define HSPH_DIV_MSB   15
`define HSPH_DIV_LSB   0
`define HSPH_PAR_MSB   17
`define HSPH_PAR_LSB   16
`define HSPH_CFG_STOP2 18
`define HSPH_CFG_FLOW  19
`define HSPH_CFG_HSPD  20
`define HSPH_CFG_RPOLL 21

// link control bits
`define HSPH_LNK_RING 0
`define HSPH_LNK_LIVE 1

// event bits, shared by status, clear and enable
`define HSPH_EV_RX   0
`define HSPH_EV_TX   1
`define HSPH_EV_PERR 2
`define HSPH_EV_FERR 3
`define HSPH_EV_OVR  4
`define HSPH_EV_DSR  5
`define HSPH_EV_RING 6
`define HSPH_EV_W    7

// status bits
`define HSPH_ST_TXBUSY 0
`define HSPH_ST_RXFULL 1
`define HSPH_ST_CTS    2
`define HSPH_ST_DSR    3
`define HSPH_ST_RING   4
`define HSPH_ST_LIVE   5
`define HSPH_ST_BOOT   6

`endif

// >>> inc/hsph_if.sv
`timescale 1ns/1ps
interface hsph_if;
  logic dev_txd;
  logic host_txd;
  logic dev_rts_n;
  logic host_rts_n;
  logic dev_ring_o;
  logic dev_ring_oe;
  logic host_ring_o;
  logic host_ring_oe;
  logic incoming_call_indicator_n;
  logic link_live_indicator_n;
  logic dsr_n;

  // ring line resolves high unless a driver pulls it
  assign incoming_call_indicator_n = (dev_ring_oe ? dev_ring_o : 1'b1)
                                   & (host_ring_oe ? host_ring_o : 1'b1);

  modport dev (
    output dev_txd, dev_rts_n, dev_ring_o, dev_ring_oe, link_live_indicator_n,
    input  host_txd, host_rts_n, incoming_call_indicator_n, dsr_n
  );
  modport host (
    output host_txd, host_rts_n, host_ring_o, host_ring_oe, dsr_n,
    input  dev_txd, dev_rts_n, incoming_call_indicator_n, link_live_indicator_n
  );
endinterface : hsph_if

// >>> inc/hsph_pkg.sv
package hsph_pkg;

  // parity selection
  typedef enum logic [1:0] {
    HSPH_PAR_NONE = 2'h0,
    HSPH_PAR_EVEN = 2'h1,
    HSPH_PAR_ODD  = 2'h2
  } hsph_parity_type;

  // character framing state, shared by transmitter and receiver
  typedef enum logic [4:0] {
    HSPH_FR_IDLE  = 5'h01,
    HSPH_FR_START = 5'h02,
    HSPH_FR_DATA  = 5'h04,
    HSPH_FR_PAR   = 5'h08,
    HSPH_FR_STOP  = 5'h10
  } hsph_frame_type;

endpackage : hsph_pkg

// >>> tb/hsph_sva.sv
`timescale 1ns/1ps
module hsph_sva (
  // clock and reset
  input logic ref_clk,
  input logic reset_n,
  // serial data and handshake lines
  input logic dev_txd,
  input logic host_txd,
  input logic dev_rts_n,
  input logic host_rts_n,
  // ring, live and ready lines
  input logic dev_ring_o,
  input logic dev_ring_oe,
  input logic host_ring_o,
  input logic host_ring_oe,
  input logic incoming_call_indicator_n,
  input logic link_live_indicator_n,
  input logic dsr_n
);
  // one domain; bits last 16 clocks in every run
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_dev_low_width: assert property ($fell(dev_txd) |-> !dev_txd [*8])
    else $error("device serial low bit too short");
  chk_dev_high_width: assert property ($rose(dev_txd) |-> dev_txd [*8])
    else $error("device serial high bit too short");
  chk_host_low_width: assert property ($fell(host_txd) |-> !host_txd [*8])
    else $error("host serial low bit too short");
  chk_host_high_width: assert property ($rose(host_txd) |-> host_txd [*8])
    else $error("host serial high bit too short");
  chk_rts_at_stop: assert property ($rose(dev_rts_n) |-> host_txd)
    else $error("device not-ready raised outside a stop bit");
  chk_host_obeys_rts: assert property ($fell(host_txd) |-> !$past(dev_rts_n))
    else $error("host started while device was not ready");
  chk_dev_obeys_cts: assert property ($fell(dev_txd) |-> !$past(host_rts_n))
    else $error("device started while host was not ready");
  chk_ring_line_driven: assert property (!incoming_call_indicator_n |->
    (dev_ring_oe && !dev_ring_o) || (host_ring_oe && !host_ring_o))
    else $error("ring line low with no driver pulling it");
  chk_dsr_drops_live: assert property ($rose(dsr_n) && !link_live_indicator_n
    |-> ##[1:6] link_live_indicator_n)
    else $error("live indicator kept after ready release");
endmodule : hsph_sva

// >>> tb/test_host_serial_port_handshake.sv
`timescale 1ns/1ps
`include "hsph_consts.svh"
module test_host_serial_port_handshake
  import hsph_pkg::*;
;
  localparam logic [31:0] BOOT    = 32'h00000010;
  localparam int          CEILING = 20000;
  // clock, reset and register port
  logic            ref_clk;
  logic            reset_n;
  logic [4:0]      reg_addr;
  logic [31:0]     reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [31:0]     reg_rdata;
  logic            irq;
  // host user side
  hsph_parity_type parity;
  logic            flow_en;
  logic            tx_valid;
  logic [7:0]      tx_data;
  logic            tx_ready;
  logic            rx_hold;
  logic            rx_valid;
  logic [7:0]      rx_data;
  logic            rx_perr;
  logic            rx_ferr;
  logic            keep_link;
  logic            ring_pull;
  logic            call_ring;
  logic            link_live;
  int              errors;
  int              n_compared;
  int              cycles;

  // both ends face each other; divisor fixed at 16 clocks a bit to keep runs short
  hsph_if hsph_if_i ();
  hsph_dev_end hsph_dev_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .boot_cfg(BOOT),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .link(hsph_if_i));
  hsph_host_end hsph_host_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .bit_div(16'h0010),
    .parity(parity), .two_stop(1'b0), .flow_en(flow_en), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_hold(rx_hold), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_perr(rx_perr), .rx_ferr(rx_ferr), .keep_link(keep_link),
    .ring_pull(ring_pull), .call_ring(call_ring), .link_live(link_live), .link(hsph_if_i));
  hsph_sva hsph_sva_i (.ref_clk(ref_clk), .reset_n(reset_n), .dev_txd(hsph_if_i.dev_txd),
    .host_txd(hsph_if_i.host_txd), .dev_rts_n(hsph_if_i.dev_rts_n),
    .host_rts_n(hsph_if_i.host_rts_n), .dev_ring_o(hsph_if_i.dev_ring_o),
    .dev_ring_oe(hsph_if_i.dev_ring_oe), .host_ring_o(hsph_if_i.host_ring_o),
    .host_ring_oe(hsph_if_i.host_ring_oe),
    .incoming_call_indicator_n(hsph_if_i.incoming_call_indicator_n),
    .link_live_indicator_n(hsph_if_i.link_live_indicator_n), .dsr_n(hsph_if_i.dsr_n));

  // free-running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == CEILING)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  // sample just past the edge so flops have landed
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    compare($sformatf("reg %h", a), e, reg_rdata & m);
  endtask : rdchk

  task automatic wait_rx();
    for (int i = 0; i < 400 && rx_valid !== 1'b1; i++)
      tick(1);
    compare("rx_valid", 32'h1, rx_valid);
  endtask : wait_rx

  // request held until ready is seen at the taking edge
  task automatic host_send(input logic [7:0] d);
    @(posedge ref_clk);
    tx_valid <= 1'b1;
    tx_data  <= d;
    #1;
    while (tx_ready !== 1'b1)
      tick(1);
    @(posedge ref_clk);
    tx_valid <= 1'b0;
  endtask : host_send

  function automatic logic [31:0] mkcfg(input hsph_parity_type p, input logic f, h, r);
    mkcfg = {10'h000, r, h, f, 1'b0, p, 16'h0010};
  endfunction : mkcfg

  task automatic s_reset();
    compare("dev_txd", 32'h1, hsph_if_i.dev_txd);
    compare("ring line", 32'h1, hsph_if_i.incoming_call_indicator_n);
    compare("live line", 32'h1, hsph_if_i.link_live_indicator_n);
    rdchk(`HSPH_A_CFG, 32'hFFFFFFFF, BOOT);
    rdchk(`HSPH_A_STAT, 32'h00000060, 32'h00000040);
    rdchk(5'h02, 32'hFFFFFFFF, 32'h00000000);
    rdchk(`HSPH_A_ICLR, 32'hFFFFFFFF, 32'h00000000);
  endtask : s_reset

  // every parity mode, then two deliberate mismatches and two stop bits
  task automatic s_dev_tx();
    logic [7:0] d [3] = '{8'hA5, 8'h07, 8'hFE};
    for (int i = 0; i < 3; i++)
    begin
      wr(`HSPH_A_CFG, mkcfg(hsph_parity_type'(i), 1'b0, 1'b0, 1'b0));
      parity <= hsph_parity_type'(i);
      wr(`HSPH_A_TXD, {24'h000000, d[i]});
      wait_rx();
      compare("rx_data", {24'h000000, d[i]}, rx_data);
      compare("rx_perr", 32'h0, rx_perr);
      compare("rx_ferr", 32'h0, rx_ferr);
    end
    wr(`HSPH_A_CFG, mkcfg(HSPH_PAR_ODD, 1'b0, 1'b0, 1'b0));
    parity <= HSPH_PAR_EVEN;
    wr(`HSPH_A_TXD, 32'h00000033);
    wait_rx();
    compare("rx_perr", 32'h1, rx_perr);
    // parity bit of 0x33 is low, so a no-parity host sees a bad stop bit
    wr(`HSPH_A_CFG, mkcfg(HSPH_PAR_EVEN, 1'b0, 1'b0, 1'b0));
    parity <= HSPH_PAR_NONE;
    wr(`HSPH_A_TXD, 32'h00000033);
    wait_rx();
    compare("rx_ferr", 32'h1, rx_ferr);
    // two stop bits: the queued character must not start inside the second one
    wr(`HSPH_A_CFG, mkcfg(HSPH_PAR_NONE, 1'b0, 1'b0, 1'b0) | (32'h1 << `HSPH_CFG_STOP2));
    tick(24);
    wr(`HSPH_A_TXD, 32'h00000081);
    wr(`HSPH_A_TXD, 32'h00000042);
    wait_rx();
    compare("rx_data", 32'h00000081, rx_data);
    tick(20);
    compare("dev_txd second stop", 32'h1, hsph_if_i.dev_txd);
    wait_rx();
    compare("rx_data", 32'h00000042, rx_data);
  endtask : s_dev_tx

  // host to device with flow control on, then device held off by the host
  task automatic s_flow();
    wr(`HSPH_A_IEN, 32'h00000001);
    wr(`HSPH_A_CFG, mkcfg(HSPH_PAR_NONE, 1'b1, 1'b0, 1'b0));
    parity  <= HSPH_PAR_NONE;
    flow_en <= 1'b1;
    host_send(8'h96);
    for (int i = 0; i < 400 && irq !== 1'b1; i++)
      tick(1);
    compare("irq", 32'h1, irq);
    compare("dev_rts_n", 32'h1, hsph_if_i.dev_rts_n);
    rdchk(`HSPH_A_RXD, 32'h000000FF, 32'h00000096);
    compare("dev_rts_n", 32'h0, hsph_if_i.dev_rts_n);
    wr(`HSPH_A_ICLR, 32'h00000001);
    #1;
    compare("irq", 32'h0, irq);
    @(posedge ref_clk);
    rx_hold <= 1'b1;
    tick(3);
    compare("host_rts_n", 32'h1, hsph_if_i.host_rts_n);
    wr(`HSPH_A_TXD, 32'h0000005A);
    tick(64);
    compare("dev_txd held", 32'h1, hsph_if_i.dev_txd);
    @(posedge ref_clk);
    rx_hold <= 1'b0;
    wait_rx();
    compare("rx_data", 32'h0000005A, rx_data);
    wr(`HSPH_A_CFG, BOOT);
    flow_en <= 1'b0;
  endtask : s_flow

  task automatic s_link();
    wr(`HSPH_A_LINK, 32'h00000003);
    tick(3);
    compare("call_ring", 32'h1, call_ring);
    compare("link_live", 32'h1, link_live);
    rdchk(`HSPH_A_STAT, 32'h00000030, 32'h00000030);
    wr(`HSPH_A_LINK, 32'h00000000);
    tick(3);
    compare("call_ring", 32'h0, call_ring);
    compare("link_live", 32'h0, link_live);
    compare("live line", 32'h1, hsph_if_i.link_live_indicator_n);
    wr(`HSPH_A_IEN, 32'h00000040);
    wr(`HSPH_A_CFG, mkcfg(HSPH_PAR_NONE, 1'b0, 1'b0, 1'b1));
    ring_pull <= 1'b1;
    tick(6);
    compare("irq", 32'h1, irq);
    rdchk(`HSPH_A_ISTAT, 32'h00000040, 32'h00000040);
    @(posedge ref_clk);
    ring_pull <= 1'b0;
    wr(`HSPH_A_ICLR, 32'h000000FF);
  endtask : s_link

  task automatic s_high_speed();
    wr(`HSPH_A_CFG, mkcfg(HSPH_PAR_NONE, 1'b0, 1'b1, 1'b0));
    keep_link <= 1'b1;
    wr(`HSPH_A_LINK, 32'h00000002);
    tick(3);
    rdchk(`HSPH_A_STAT, 32'h00000028, 32'h00000028);
    @(posedge ref_clk);
    keep_link <= 1'b0;
    tick(8);
    compare("live line", 32'h1, hsph_if_i.link_live_indicator_n);
    rdchk(`HSPH_A_ISTAT, 32'h00000020, 32'h00000020);
  endtask : s_high_speed

  // main sequence
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, tx_valid, tx_data} = '0;
    {reset_n, flow_en, rx_hold, keep_link, ring_pull} = '0;
    parity = HSPH_PAR_NONE;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    tick(2);
    s_reset();
    s_dev_tx();
    s_flow();
    s_link();
    s_high_speed();
    tally_and_finish();
  end
endmodule : test_host_serial_port_handshake

// >>> verilog/hsph_char_engine.sv
`timescale 1ns/1ps
`include "hsph_consts.svh"
module hsph_char_engine
  import hsph_pkg::*;
(
  // clock and reset
  input  logic            ref_clk,
  input  logic            reset_n,
  // framing settings
  input  logic [15:0]     bit_div,
  input  hsph_parity_type parity,
  input  logic            two_stop,
  // transmit side
  input  logic            tx_valid,
  input  logic [7:0]      tx_data,
  output logic            tx_ready,
  output logic            txd,
  // receive side
  input  logic            rxd,
  output logic            rx_done,
  output logic [7:0]      rx_data,
  output logic            rx_perr,
  output logic            rx_ferr
);
  hsph_frame_type tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [15:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [2:0]  tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
  logic [7:0]  tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
  logic        txd_q, txd_d, tx_par_q, tx_par_d, tx_s2_q, tx_s2_d;
  logic        rx_pe_q, rx_pe_d, done_q, done_d, perr_q, perr_d, ferr_q, ferr_d;
  logic        tx_tick, rx_tick, rx_half, odd;

  assign odd      = (parity == HSPH_PAR_ODD);
  assign tx_tick  = (tx_cnt_q == 16'(bit_div - 16'h0001));
  assign rx_tick  = (rx_cnt_q == 16'(bit_div - 16'h0001));
  assign rx_half  = (rx_cnt_q == 16'({1'b0, bit_div[15:1]} - 16'h0001));
  assign tx_ready = (tx_st_q == HSPH_FR_IDLE);
  assign txd      = txd_q;
  assign rx_done  = done_q;
  assign rx_data  = rx_data_q;
  assign rx_perr  = perr_q;
  assign rx_ferr  = ferr_q;

  // transmit framing: start low, lsb first, parity, high stop bits
  always_comb
  begin
    tx_st_d  = tx_st_q;
    tx_cnt_d = tx_tick ? 16'h0000 : 16'(tx_cnt_q + 16'h0001);
    tx_bit_d = tx_bit_q;
    tx_sh_d  = tx_sh_q;
    txd_d    = txd_q;
    tx_par_d = tx_par_q;
    tx_s2_d  = tx_s2_q;
    unique case (tx_st_q)
      HSPH_FR_IDLE:
      begin
        txd_d    = 1'b1;
        tx_cnt_d = 16'h0000;
        if (tx_valid)
        begin
          tx_sh_d  = tx_data;
          tx_par_d = (^tx_data) ^ odd;
          txd_d    = 1'b0;
          tx_st_d  = HSPH_FR_START;
        end
      end
      HSPH_FR_START:
        if (tx_tick)
        begin
          txd_d    = tx_sh_q[0];
          tx_bit_d = 3'h0;
          tx_st_d  = HSPH_FR_DATA;
        end
      HSPH_FR_DATA:
        if (tx_tick)
        begin
          if (tx_bit_q == 3'h7)
          begin
            tx_s2_d = two_stop;
            txd_d   = (parity == HSPH_PAR_NONE) ? 1'b1 : tx_par_q;
            tx_st_d = (parity == HSPH_PAR_NONE) ? HSPH_FR_STOP : HSPH_FR_PAR;
          end
          else
          begin
            tx_sh_d  = {1'b0, tx_sh_q[7:1]};
            txd_d    = tx_sh_q[1];
            tx_bit_d = 3'(tx_bit_q + 3'h1);
          end
        end
      HSPH_FR_PAR:
        if (tx_tick)
        begin
          txd_d   = 1'b1;
          tx_st_d = HSPH_FR_STOP;
        end
      HSPH_FR_STOP:
        if (tx_tick)
        begin
          if (tx_s2_q)
            tx_s2_d = 1'b0;
          else
            tx_st_d = HSPH_FR_IDLE;
        end
      default:
        tx_st_d = HSPH_FR_IDLE;
    endcase
  end

  // receive framing; start confirmed mid-bit to reject glitches
  always_comb
  begin
    rx_st_d   = rx_st_q;
    rx_cnt_d  = rx_tick ? 16'h0000 : 16'(rx_cnt_q + 16'h0001);
    rx_bit_d  = rx_bit_q;
    rx_sh_d   = rx_sh_q;
    rx_pe_d   = rx_pe_q;
    rx_data_d = rx_data_q;
    done_d    = 1'b0;
    perr_d    = perr_q;
    ferr_d    = ferr_q;
    unique case (rx_st_q)
      HSPH_FR_IDLE:
      begin
        rx_cnt_d = 16'h0000;
        if (!rxd)
          rx_st_d = HSPH_FR_START;
      end
      HSPH_FR_START:
        if (rx_half)
        begin
          rx_cnt_d = 16'h0000;
          rx_bit_d = 3'h0;
          rx_pe_d  = 1'b0;
          rx_st_d  = rxd ? HSPH_FR_IDLE : HSPH_FR_DATA;
        end
      HSPH_FR_DATA:
        if (rx_tick)
        begin
          rx_sh_d  = {rxd, rx_sh_q[7:1]};
          rx_bit_d = 3'(rx_bit_q + 3'h1);
          if (rx_bit_q == 3'h7)
            rx_st_d = (parity == HSPH_PAR_NONE) ? HSPH_FR_STOP : HSPH_FR_PAR;
        end
      HSPH_FR_PAR:
        if (rx_tick)
        begin
          rx_pe_d = rxd ^ (^rx_sh_q) ^ odd;
          rx_st_d = HSPH_FR_STOP;
        end
      HSPH_FR_STOP:
        if (rx_tick)
        begin
          // only the first stop bit is checked, as usual receivers do
          rx_data_d = rx_sh_q;
          perr_d    = rx_pe_q;
          ferr_d    = !rxd;
          done_d    = 1'b1;
          rx_st_d   = HSPH_FR_IDLE;
        end
      default:
        rx_st_d = HSPH_FR_IDLE;
    endcase
  end

  // register both framers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_st_q   <= HSPH_FR_IDLE;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 3'h0;
      tx_sh_q   <= 8'h00;
      txd_q     <= 1'b1;
      tx_par_q  <= 1'b0;
      tx_s2_q   <= 1'b0;
      rx_st_q   <= HSPH_FR_IDLE;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_pe_q   <= 1'b0;
      rx_data_q <= 8'h00;
      done_q    <= 1'b0;
      perr_q    <= 1'b0;
      ferr_q    <= 1'b0;
    end
    else
    begin
      tx_st_q   <= tx_st_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      txd_q     <= txd_d;
      tx_par_q  <= tx_par_d;
      tx_s2_q   <= tx_s2_d;
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_bit_q  <= rx_bit_d;
      rx_sh_q   <= rx_sh_d;
      rx_pe_q   <= rx_pe_d;
      rx_data_q <= rx_data_d;
      done_q    <= done_d;
      perr_q    <= perr_d;
      ferr_q    <= ferr_d;
    end
  end
endmodule : hsph_char_engine

// >>> verilog/hsph_dev_end.sv
`timescale 1ns/1ps
`include "hsph_consts.svh"
module hsph_dev_end
  import hsph_pkg::*;
(
  // clock and reset
  input  logic        ref_clk,
  input  logic        reset_n,
  // power-up settings from flash
  input  logic [31:0] boot_cfg,
  // register port
  input  logic [4:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic        irq,
  // link to host
  hsph_if.dev         link
);
  logic [31:0]           cfg_q, cfg_d, rdata_q, rdata_d;
  logic                  boot_q, boot_d, ring_q, ring_d, live_q, live_d;
  logic [7:0]            txb_q, txb_d, rxb_q, rxb_d;
  logic                  txp_q, txp_d, rxf_q, rxf_d;
  logic                  rdy_q, dsr_q, rline_q;
  logic [`HSPH_EV_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
  logic [`HSPH_EV_W-1:0] clr;
  logic                  eng_ready, eng_valid, eng_done, eng_perr, eng_ferr;
  logic                  flow, hspd, rpoll, cts, wr_tx, rd_rx;
  logic [7:0]            eng_data;
  logic [31:0]           stat;

  assign flow  = cfg_q[`HSPH_CFG_FLOW];
  assign hspd  = cfg_q[`HSPH_CFG_HSPD];
  assign rpoll = cfg_q[`HSPH_CFG_RPOLL];
  assign cts   = !link.host_rts_n;
  assign wr_tx = reg_wr && (reg_addr == `HSPH_A_TXD);
  assign rd_rx = reg_rd && (reg_addr == `HSPH_A_RXD);
  assign clr   = (reg_wr && (reg_addr == `HSPH_A_ICLR)) ? reg_wdata[`HSPH_EV_W-1:0]
                                                        : '0;

  // with flow control on, send only while the host says it can take a character
  assign eng_valid = txp_q && (!flow || cts);

  hsph_char_engine u_engine (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .bit_div  (cfg_q[`HSPH_DIV_MSB:`HSPH_DIV_LSB]),
    .parity   (hsph_parity_type'(cfg_q[`HSPH_PAR_MSB:`HSPH_PAR_LSB])),
    .two_stop (cfg_q[`HSPH_CFG_STOP2]),
    .tx_valid (eng_valid),
    .tx_data  (txb_q),
    .tx_ready (eng_ready),
    .txd      (link.dev_txd),
    .rxd      (link.host_txd),
    .rx_done  (eng_done),
    .rx_data  (eng_data),
    .rx_perr  (eng_perr),
    .rx_ferr  (eng_ferr)
  );

  // handshake and indicator pins
  assign link.dev_rts_n            = flow ? rxf_q : 1'b0;
  assign link.dev_ring_o           = !ring_q;
  assign link.dev_ring_oe          = !rpoll;
  assign link.link_live_indicator_n = !live_q;

  // events: one-cycle pulses into the sticky status
  always_comb
  begin
    ev                = '0;
    ev[`HSPH_EV_RX]   = eng_done;
    ev[`HSPH_EV_TX]   = eng_ready && !rdy_q;
    ev[`HSPH_EV_PERR] = eng_done && eng_perr;
    ev[`HSPH_EV_FERR] = eng_done && eng_ferr;
    ev[`HSPH_EV_OVR]  = eng_done && rxf_q && !rd_rx;
    ev[`HSPH_EV_DSR]  = hspd && link.dsr_n && !dsr_q;
    ev[`HSPH_EV_RING] = rpoll && rline_q && !link.incoming_call_indicator_n;
  end

  // settings, link control and the two data holders
  always_comb
  begin
    cfg_d  = cfg_q;
    boot_d = 1'b1;
    ring_d = ring_q;
    live_d = live_q;
    txb_d  = txb_q;
    txp_d  = txp_q;
    rxb_d  = rxb_q;
    rxf_d  = rxf_q;
    if (!boot_q)
      cfg_d = boot_cfg;
    else if (reg_wr && (reg_addr == `HSPH_A_CFG))
      cfg_d = reg_wdata;
    if (reg_wr && (reg_addr == `HSPH_A_LINK))
    begin
      ring_d = reg_wdata[`HSPH_LNK_RING];
      live_d = reg_wdata[`HSPH_LNK_LIVE];
    end
    // a dropped ready in high speed mode ends the connection
    if (ev[`HSPH_EV_DSR])
      live_d = 1'b0;
    if (eng_valid && eng_ready)
      txp_d = 1'b0;
    // a write while a character waits is ignored, never overwrites it
    if (wr_tx && !txp_q)
    begin
      txb_d = reg_wdata[7:0];
      txp_d = 1'b1;
    end
    if (rd_rx)
      rxf_d = 1'b0;
    // newest character wins on overrun; arrival beats the read clear
    if (eng_done)
    begin
      rxb_d = eng_data;
      rxf_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q  <= `HSPH_CFG_RST;
      boot_q <= 1'b0;
      ring_q <= 1'b0;
      live_q <= 1'b0;
      txb_q  <= 8'h00;
      txp_q  <= 1'b0;
      rxb_q  <= 8'h00;
      rxf_q  <= 1'b0;
    end
    else
    begin
      cfg_q  <= cfg_d;
      boot_q <= boot_d;
      ring_q <= ring_d;
      live_q <= live_d;
      txb_q  <= txb_d;
      txp_q  <= txp_d;
      rxb_q  <= rxb_d;
      rxf_q  <= rxf_d;
    end
  end

  // edge history for events
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdy_q   <= 1'b1;
      dsr_q   <= 1'b1;
      rline_q <= 1'b1;
    end
    else
    begin
      rdy_q   <= eng_ready;
      dsr_q   <= link.dsr_n;
      rline_q <= link.incoming_call_indicator_n;
    end
  end

  // interrupt status: a new event wins over a clear in the same cycle
  always_comb
  begin
    ist_d = (ist_q & ~clr) | ev;
    ien_d = (reg_wr && (reg_addr == `HSPH_A_IEN)) ? reg_wdata[`HSPH_EV_W-1:0] : ien_q;
  end

  assign irq = |(ist_q & ien_q);

  // read mux; unmapped and write-only addresses read zero
  always_comb
  begin
    stat                  = '0;
    stat[`HSPH_ST_TXBUSY] = txp_q || !eng_ready;
    stat[`HSPH_ST_RXFULL] = rxf_q;
    stat[`HSPH_ST_CTS]    = cts;
    stat[`HSPH_ST_DSR]    = !link.dsr_n;
    stat[`HSPH_ST_RING]   = !link.incoming_call_indicator_n;
    stat[`HSPH_ST_LIVE]   = live_q;
    stat[`HSPH_ST_BOOT]   = boot_q;
    rdata_d               = 32'h00000000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `HSPH_A_CFG:   rdata_d = cfg_q;
        `HSPH_A_RXD:   rdata_d = {24'h000000, rxb_q};
        `HSPH_A_STAT:  rdata_d = stat;
        `HSPH_A_LINK:  rdata_d = {30'h00000000, live_q, ring_q};
        `HSPH_A_ISTAT: rdata_d = {25'h0000000, ist_q};
        `HSPH_A_IEN:   rdata_d = {25'h0000000, ien_q};
        default:       rdata_d = 32'h00000000;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ist_q   <= '0;
      ien_q   <= '0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ist_q   <= ist_d;
      ien_q   <= ien_d;
      rdata_q <= rdata_d;
    end
  end
endmodule : hsph_dev_end

// >>> verilog/hsph_host_end.sv
`timescale 1ns/1ps
`include "hsph_consts.svh"
module hsph_host_end
  import hsph_pkg::*;
(
  // clock and reset
  input  logic            ref_clk,
  input  logic            reset_n,
  // framing settings
  input  logic [15:0]     bit_div,
  input  hsph_parity_type parity,
  input  logic            two_stop,
  input  logic            flow_en,
  // user transmit
  input  logic            tx_valid,
  input  logic [7:0]      tx_data,
  output logic            tx_ready,
  // user receive
  input  logic            rx_hold,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_perr,
  output logic            rx_ferr,
  // link control and indicators
  input  logic            keep_link,
  input  logic            ring_pull,
  output logic            call_ring,
  output logic            link_live,
  // link to device
  hsph_if.host            link
);
  logic allow, eng_ready, ring_q, live_q, dsr_n_q, rts_n_q;

  // with flow_en set, send only while the device's request line is asserted
  assign allow    = !flow_en || !link.dev_rts_n;
  assign tx_ready = eng_ready && allow;

  hsph_char_engine u_engine (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .bit_div  (bit_div),
    .parity   (parity),
    .two_stop (two_stop),
    .tx_valid (tx_valid && allow),
    .tx_data  (tx_data),
    .tx_ready (eng_ready),
    .txd      (link.host_txd),
    .rxd      (link.dev_txd),
    .rx_done  (rx_valid),
    .rx_data  (rx_data),
    .rx_perr  (rx_perr),
    .rx_ferr  (rx_ferr)
  );

  assign link.dsr_n        = dsr_n_q;
  assign link.host_rts_n   = rts_n_q;
  assign link.host_ring_o  = 1'b0;
  assign link.host_ring_oe = ring_pull;
  assign call_ring         = ring_q;
  assign link_live         = live_q;

  // terminal-ready held low for as long as the link should stay
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dsr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
      ring_q  <= 1'b0;
      live_q  <= 1'b0;
    end
    else
    begin
      dsr_n_q <= !keep_link;
      rts_n_q <= flow_en && rx_hold;
      ring_q  <= !link.incoming_call_indicator_n;
      live_q  <= !link.link_live_indicator_n;
    end
  end
endmodule : hsph_host_end
